// ### i2cm_defines.svh
// Purpose: Register offsets, field positions and reset values of the
//          multi-master two-wire serial port.
// Assumes: Included by bare name; definitions only.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

`define I2CM_OFF_CTRL     8'h00
`define I2CM_OFF_CON2     8'h04
`define I2CM_OFF_STAT     8'h08
`define I2CM_OFF_RATE     8'h0C
`define I2CM_OFF_BUF      8'h10

`define I2CM_CTRL_EN      0
`define I2CM_CTRL_IE      1

`define I2CM_CON2_SEN     0
`define I2CM_CON2_RSEN    1
`define I2CM_CON2_PEN     2
`define I2CM_CON2_ACKEN   3
`define I2CM_CON2_ACKDT   5
`define I2CM_CON2_ACKSTAT 6

`define I2CM_STAT_BUF     0
`define I2CM_STAT_START   1
`define I2CM_STAT_STOP    2
`define I2CM_STAT_EVENT   3
`define I2CM_STAT_COLL    4
`define I2CM_STAT_BUSY    5

`define I2CM_RATE_RST     8'h09
`define I2CM_RESP_OKAY    2'h0
`define I2CM_RESP_SLVERR  2'h2

`endif

// ### i2cm_pkg.sv
// Purpose: Types of the multi-master two-wire serial port.
// Assumes: Nothing beyond the defines header.
// Notes:   State codes are written out for readable waveforms.
package i2cm_pkg;
  typedef enum logic [3:0] {
    I2CM_IDLE   = 4'h0,
    I2CM_S_CNT  = 4'h1,
    I2CM_S_HOLD = 4'h2,
    I2CM_R_REL  = 4'h3,
    I2CM_R_SCL  = 4'h4,
    I2CM_R_CNT  = 4'h5,
    I2CM_R_HOLD = 4'h6,
    I2CM_B_LOW  = 4'h7,
    I2CM_B_HIGH = 4'h8,
    I2CM_P_LOW  = 4'h9,
    I2CM_P_SCL  = 4'hA,
    I2CM_P_CNT  = 4'hB,
    I2CM_P_SDA  = 4'hC
  } i2cm_state_t;
endpackage

// ### i2cm_arb.sv
// Purpose: Two-wire serial master with multi-master arbitration,
//          bus-free tracking and collision abort, AXI4-Lite registers.
// Assumes: aclk 10 MHz; scl/sda pins are asynchronous and open drain.
// Notes:   Master receive and slave address matching are not built.
//
// Overview of operation
// - In sleep with interrupt enabled, a finished event raises the wake output.
// - Reset or disable releases the pins and abandons any transfer.
// - Stop-seen and Start-seen clear on reset and while disabled.
// - Start is accepted only after Stop-seen, or with both flags clear.
// - A Stop seen on the bus sets the serial event flag.
// - Driven SDA is compared with sampled SDA in every arbitrated phase.
// - Released SDA read low with SCL high in a bit we send sets collision, port goes idle.
// - Byte collision halts output, clears buffer-full, releases both lines.
// - Sequence collision aborts it, releases lines, clears its enable bit.
// - After a collision the bus monitor still flags a Stop.
// - A buffer write after a collision starts from the first bit.
// - SDA or SCL low at Start begin aborts it and sets collision.
// - Start counts with SDA high; SCL low then is a collision.
// - SDA low during the Start count drives SDA low early, no collision.
// - Start drives SDA low, counts ignoring SCL, then drives SCL low.
// - Repeated Start: release SDA, count, release SCL; SDA low is collision.
// - SDA falling during the Repeated Start count is not a collision.
// - SCL falling before we drive SDA in Repeated Start is a collision.
// - Repeated Start then drives SDA low, counts, and drives SCL low.
// - Stop drives SDA low, releases SCL, counts once SCL is high.
// - Released SDA reading low after the Stop count is a collision.
// - SCL low after SDA is released in Stop is a collision.
// - Every interval is one rollover of a counter reloaded from RATE.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_defines.svh"

module i2cm_arb
  import i2cm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        sleep_mode,
  output logic             wake
);

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `I2CM_OFF_CTRL) || (a == `I2CM_OFF_CON2) ||
               (a == `I2CM_OFF_STAT) || (a == `I2CM_OFF_RATE) ||
               (a == `I2CM_OFF_BUF);
  endfunction

  // Pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl;
  logic       sda;
  logic       scl_p;
  logic       sda_p;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_p    <= 1'b1;
      sda_p    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_p    <= scl;
      sda_p    <= sda;
    end
  end

  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // Register state
  logic        en;
  logic        ie;
  logic        sen;
  logic        rsen;
  logic        pen;
  logic        acken;
  logic        ackdt;
  logic        ackstat;
  logic [7:0]  rate;
  logic [7:0]  txbyte;
  logic        buf_full;
  logic        start_seen;
  logic        stop_seen;
  logic        ev_flag;
  logic        col_flag;
  logic        set_ev;
  logic        set_col;
  i2cm_state_t state;

  // AXI4-Lite write channel
  logic        aw_ok;
  logic        w_ok;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic        wlane0;
  logic        wr_en;

  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok && !s_axi_bvalid;
  assign wr_en = aw_ok && w_ok && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok        <= 1'b0;
      w_ok         <= 1'b0;
      waddr        <= 8'h00;
      wdata        <= 32'h0000_0000;
      wlane0       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `I2CM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        waddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok   <= 1'b1;
        wdata  <= s_axi_wdata;
        wlane0 <= s_axi_wstrb[0];
      end
      if (wr_en) begin
        aw_ok        <= 1'b0;
        w_ok         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(waddr) ? `I2CM_RESP_OKAY
                                        : `I2CM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_lo;
  assign wr_lo = wr_en && wlane0;

  // AXI4-Lite read channel
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `I2CM_OFF_CTRL: begin
        rd_word[`I2CM_CTRL_EN] = en;
        rd_word[`I2CM_CTRL_IE] = ie;
      end
      `I2CM_OFF_CON2: begin
        rd_word[`I2CM_CON2_SEN]     = sen;
        rd_word[`I2CM_CON2_RSEN]    = rsen;
        rd_word[`I2CM_CON2_PEN]     = pen;
        rd_word[`I2CM_CON2_ACKEN]   = acken;
        rd_word[`I2CM_CON2_ACKDT]   = ackdt;
        rd_word[`I2CM_CON2_ACKSTAT] = ackstat;
      end
      `I2CM_OFF_STAT: begin
        rd_word[`I2CM_STAT_BUF]   = buf_full;
        rd_word[`I2CM_STAT_START] = start_seen;
        rd_word[`I2CM_STAT_STOP]  = stop_seen;
        rd_word[`I2CM_STAT_EVENT] = ev_flag;
        rd_word[`I2CM_STAT_COLL]  = col_flag;
        rd_word[`I2CM_STAT_BUSY]  = (state != I2CM_IDLE);
      end
      `I2CM_OFF_RATE: rd_word[7:0] = rate;
      `I2CM_OFF_BUF:  rd_word[7:0] = txbyte;
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `I2CM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? `I2CM_RESP_OKAY
                                             : `I2CM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bus monitor keeps running through collisions so bus-free is known
  logic start_det;
  logic stop_det;

  assign start_det = scl && scl_p && sda_p && !sda;
  assign stop_det  = scl && scl_p && !sda_p && sda;

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else if (start_det) begin
      start_seen <= 1'b1;
      stop_seen  <= 1'b0;
    end else if (stop_det) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b1;
    end
  end

  // Sequencer
  logic [7:0] cnt;
  logic       tick;
  logic [8:0] shreg;
  logic [3:0] bits_left;
  logic       is_tx;
  logic       hi;
  logic       col_now;
  logic       bus_free;
  logic       wr_con2;
  logic       wr_buf;

  assign tick = (cnt == 8'h00);
  assign bus_free = stop_seen || (!start_seen && !stop_seen);
  assign wr_con2 = wr_lo && (waddr == `I2CM_OFF_CON2);
  assign wr_buf  = wr_lo && (waddr == `I2CM_OFF_BUF);

  always_comb begin
    case (state)
      I2CM_S_CNT:  col_now = sda && !scl;
      I2CM_R_SCL:  col_now = scl && !sda;
      I2CM_R_CNT:  col_now = !scl && sda_oe_n;
      I2CM_B_HIGH: col_now = hi && scl && sda_oe_n && !sda &&
                             !(is_tx && bits_left == 4'h1);
      I2CM_P_SDA:  col_now = !scl || (tick && !sda);
      default:     col_now = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      state     <= I2CM_IDLE;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
      sen       <= 1'b0;
      rsen      <= 1'b0;
      pen       <= 1'b0;
      acken     <= 1'b0;
      buf_full  <= 1'b0;
      cnt       <= 8'h00;
      shreg     <= 9'h000;
      bits_left <= 4'h0;
      is_tx     <= 1'b0;
      hi        <= 1'b0;
      ackstat   <= 1'b0;
      set_ev    <= 1'b0;
      set_col   <= 1'b0;
    end else begin
      set_ev  <= 1'b0;
      set_col <= 1'b0;
      if (!tick) begin
        cnt <= cnt - 8'h01;
      end
      if (col_now) begin
        state    <= I2CM_IDLE;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        sen      <= 1'b0;
        rsen     <= 1'b0;
        pen      <= 1'b0;
        acken    <= 1'b0;
        buf_full <= 1'b0;
        set_col  <= 1'b1;
      end else begin
        case (state)
          I2CM_IDLE: begin
            if (wr_buf) begin
              shreg     <= {wdata[7:0], 1'b1};
              bits_left <= 4'h9;
              is_tx     <= 1'b1;
              buf_full  <= 1'b1;
              cnt       <= rate;
              state     <= I2CM_B_LOW;
            end else if (wr_con2 && wdata[`I2CM_CON2_SEN] && bus_free) begin
              if (!sda || !scl) begin
                set_col <= 1'b1;
              end else begin
                sen   <= 1'b1;
                cnt   <= rate;
                state <= I2CM_S_CNT;
              end
            end else if (wr_con2 && wdata[`I2CM_CON2_RSEN]) begin
              rsen     <= 1'b1;
              sda_oe_n <= 1'b1;
              cnt      <= rate;
              state    <= I2CM_R_REL;
            end else if (wr_con2 && wdata[`I2CM_CON2_PEN]) begin
              pen      <= 1'b1;
              sda_oe_n <= 1'b0;
              state    <= I2CM_P_LOW;
            end else if (wr_con2 && wdata[`I2CM_CON2_ACKEN]) begin
              acken     <= 1'b1;
              shreg     <= {ackdt, 8'h00};
              bits_left <= 4'h1;
              is_tx     <= 1'b0;
              cnt       <= rate;
              state     <= I2CM_B_LOW;
            end
          end
          I2CM_S_CNT: begin
            if (!sda || tick) begin
              sda_oe_n <= 1'b0;
              cnt      <= rate;
              state    <= I2CM_S_HOLD;
            end
          end
          I2CM_S_HOLD: begin
            if (tick) begin
              scl_oe_n <= 1'b0;
              sen      <= 1'b0;
              set_ev   <= 1'b1;
              state    <= I2CM_IDLE;
            end
          end
          I2CM_R_REL: begin
            if (tick) begin
              scl_oe_n <= 1'b1;
              state    <= I2CM_R_SCL;
            end
          end
          I2CM_R_SCL: begin
            if (scl) begin
              cnt   <= rate;
              state <= I2CM_R_CNT;
            end
          end
          I2CM_R_CNT: begin
            if (tick) begin
              sda_oe_n <= 1'b0;
              cnt      <= rate;
              state    <= I2CM_R_HOLD;
            end
          end
          I2CM_R_HOLD: begin
            if (tick) begin
              scl_oe_n <= 1'b0;
              rsen     <= 1'b0;
              set_ev   <= 1'b1;
              state    <= I2CM_IDLE;
            end
          end
          I2CM_B_LOW: begin
            scl_oe_n <= 1'b0;
            sda_oe_n <= shreg[8];
            if (tick) begin
              scl_oe_n <= 1'b1;
              hi       <= 1'b0;
              state    <= I2CM_B_HIGH;
            end
          end
          I2CM_B_HIGH: begin
            // Wait out clock stretching before timing the high phase
            if (!hi && scl) begin
              hi  <= 1'b1;
              cnt <= rate;
            end else if (hi && tick) begin
              scl_oe_n  <= 1'b0;
              shreg     <= {shreg[7:0], 1'b1};
              bits_left <= bits_left - 4'h1;
              cnt       <= rate;
              state     <= I2CM_B_LOW;
              if (is_tx && bits_left == 4'h2) begin
                buf_full <= 1'b0;
              end
              if (bits_left == 4'h1) begin
                if (is_tx) begin
                  ackstat <= sda;
                end
                sda_oe_n <= 1'b1;
                acken    <= 1'b0;
                set_ev   <= 1'b1;
                state    <= I2CM_IDLE;
              end
            end
          end
          I2CM_P_LOW: begin
            if (!sda) begin
              scl_oe_n <= 1'b1;
              state    <= I2CM_P_SCL;
            end
          end
          I2CM_P_SCL: begin
            if (scl) begin
              cnt   <= rate;
              state <= I2CM_P_CNT;
            end
          end
          I2CM_P_CNT: begin
            if (tick) begin
              sda_oe_n <= 1'b1;
              cnt      <= rate;
              state    <= I2CM_P_SDA;
            end
          end
          I2CM_P_SDA: begin
            if (tick) begin
              pen    <= 1'b0;
              set_ev <= 1'b1;
              state  <= I2CM_IDLE;
            end
          end
          default: state <= I2CM_IDLE;
        endcase
      end
    end
  end

  // Software registers; flag sets win over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en    <= 1'b0;
      ie    <= 1'b0;
      ackdt <= 1'b0;
      rate  <= `I2CM_RATE_RST;
    end else if (wr_lo) begin
      if (waddr == `I2CM_OFF_CTRL) begin
        en <= wdata[`I2CM_CTRL_EN];
        ie <= wdata[`I2CM_CTRL_IE];
      end
      if (waddr == `I2CM_OFF_CON2) begin
        ackdt <= wdata[`I2CM_CON2_ACKDT];
      end
      if (waddr == `I2CM_OFF_RATE) begin
        rate <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txbyte <= 8'h00;
    end else if (wr_buf && state == I2CM_IDLE && en) begin
      txbyte <= wdata[7:0];
    end
  end

  logic clr_stat;
  assign clr_stat = wr_lo && (waddr == `I2CM_OFF_STAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_flag  <= 1'b0;
      col_flag <= 1'b0;
    end else begin
      if (set_ev || (stop_det && en)) begin
        ev_flag <= 1'b1;
      end else if (clr_stat && wdata[`I2CM_STAT_EVENT]) begin
        ev_flag <= 1'b0;
      end
      if (set_col) begin
        col_flag <= 1'b1;
      end else if (clr_stat && wdata[`I2CM_STAT_COLL]) begin
        col_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= sleep_mode && ie && ev_flag;
    end
  end

endmodule

`default_nettype wire

// ### i2cm_arb_properties.sv
// Purpose: Port-level properties of the arbitrating two-wire master.
// Assumes: Bound to i2cm_arb; sees only its ports.
// Notes:   Pin levels reach the logic two cycles late.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_defines.svh"

module i2cm_arb_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        scl_in,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        sleep_mode,
  input wire logic        wake
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_release: assert property (
    $rose(aresetn) |-> sda_oe_n && scl_oe_n && !wake)
    else $error("pins held or wake high after reset");
  chk_wake_sleep: assert property (
    !sleep_mode |=> !wake)
    else $error("wake raised while awake");
  // Every interval is a full rollover, so a driven low phase is never short
  chk_scl_low_min: assert property (
    $fell(scl_oe_n) |=> !scl_oe_n [*3])
    else $error("clock low phase too short");
  // Another party holding the clock low must keep us off the bus
  chk_foreign_scl: assert property (
    (scl_oe_n && sda_oe_n && !scl_in) [*4] |=> scl_oe_n && sda_oe_n)
    else $error("line driven while clock held low by another");
  chk_ar_ready: assert property (
    s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  chk_b_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_single: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  chk_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14
    |=> s_axi_rvalid && s_axi_rresp == `I2CM_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule

bind i2cm_arb i2cm_arb_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .sleep_mode(sleep_mode), .wake(wake)
);
`default_nettype wire

// ### i2cm_bus_model.sv
// Purpose: Shared two-wire bus with pull-ups and a foreign master.
// Assumes: Lines are wired-AND; released lines float high.
// Notes:   Foreign frames use an 800 ns clock, start to stop.
`timescale 1ns/1ps
`default_nettype none

module i2cm_bus_model (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  input  wire logic hold_scl,
  input  wire logic hold_sda,
  input  wire logic frame_go,
  output logic      scl,
  output logic      sda
);
  logic f_scl = 1'b1;
  logic f_sda = 1'b1;

  // Pull-ups win only when every party has let go
  assign scl = scl_oe_n & f_scl & ~hold_scl;
  assign sda = sda_oe_n & f_sda & ~hold_sda;

  // Clock stands high outside the frame
  always @(posedge frame_go) begin
    f_sda = 1'b0;
    #400 f_scl = 1'b0;
    repeat (2) begin
      #400 f_scl = 1'b1;
      #400 f_scl = 1'b0;
    end
    #400 f_scl = 1'b1;
    #400 f_sda = 1'b1;
  end
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Register-level tests of the arbitrating two-wire master.
// Assumes: Bus model pulls both lines up; aclk period 100 ns.
// Notes:   Repeated Start is not exercised here, nor by the properties.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_defines.svh"

module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, sleep_mode = 1'b0;
  logic        hold_sda = 1'b0, hold_scl = 1'b0, frame_go = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, wake;
  logic        scl_oe_n, sda_oe_n, scl_out, sda_out, collect = 1'b0;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [31:0] rdata, rd_v;
  logic [8:0]  bits;
  wire logic   scl, sda;
  int          bad_count = 0;
  int          checks = 0;

  always #50 aclk = ~aclk;

  i2cm_arb dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sleep_mode(sleep_mode), .wake(wake)
  );

  i2cm_bus_model bus_u (
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .hold_scl(hold_scl),
    .hold_sda(hold_sda), .frame_go(frame_go), .scl(scl), .sda(sda)
  );

  always @(posedge scl) begin
    if (collect) bits = {bits[7:0], sda};
  end

  task automatic test_done;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    cmp(32'h0, 32'h1);
    test_done();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        wr_r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 40) timeout();
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    if (n == 40) timeout();
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rd(a);
    cmp(rd_v & m, e);
  endtask

  // Polls a status bit; the bound stands in for a hung sequencer
  task automatic wait_stat(input int b);
    for (int n = 0; n < 400; n++) begin
      rd(`I2CM_OFF_STAT);
      if (rd_v[b] === 1'b1) return;
    end
    timeout();
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`I2CM_OFF_STAT, 32'hFFFFFFFF, 32'h0);
    rchk(`I2CM_OFF_RATE, 32'hFF, 32'h9);
    rd(8'h14);
    cmp(rd_r, `I2CM_RESP_SLVERR);
    wr(8'h14, 32'h0);
    cmp(wr_r, `I2CM_RESP_SLVERR);
    wr(`I2CM_OFF_CTRL, 32'h3);
    cmp(wr_r, `I2CM_RESP_OKAY);
    // Clock low well before the Start, so the synced level is already seen
    hold_scl <= 1'b1;
    wr(`I2CM_OFF_RATE, 32'h3);
    wr(`I2CM_OFF_CON2, 32'h1);
    wait_stat(4);
    rchk(`I2CM_OFF_CON2, 32'h1, 32'h0);
    cmp({sda_oe_n, scl_oe_n}, 32'h3);
    hold_scl <= 1'b0;
    wr(`I2CM_OFF_STAT, 32'h18);
    rchk(`I2CM_OFF_STAT, 32'h10, 32'h0);
    wr(`I2CM_OFF_CON2, 32'h1);
    wait_stat(3);
    cmp({sda_oe_n, scl_oe_n}, 32'h0);
    wr(`I2CM_OFF_STAT, 32'h8);
    hold_sda <= 1'b1;
    wr(`I2CM_OFF_BUF, 32'h80);
    wait_stat(4);
    rchk(`I2CM_OFF_STAT, 32'h1, 32'h0);
    cmp({sda_oe_n, scl_oe_n}, 32'h3);
    hold_sda <= 1'b0;
    wait_stat(3);
    rchk(`I2CM_OFF_STAT, 32'h4, 32'h4);
    wr(`I2CM_OFF_STAT, 32'h18);
    wr(`I2CM_OFF_CON2, 32'h1);
    wait_stat(3);
    wr(`I2CM_OFF_STAT, 32'h8);
    collect = 1'b1;
    wr(`I2CM_OFF_BUF, 32'h5A);
    wait_stat(3);
    collect = 1'b0;
    cmp(bits, 32'h0B5);
    rchk(`I2CM_OFF_CON2, 32'h40, 32'h40);
    wr(`I2CM_OFF_STAT, 32'h8);
    wr(`I2CM_OFF_CON2, 32'h4);
    wait_stat(3);
    cmp({sda_oe_n, scl_oe_n}, 32'h3);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp(wake, 32'h1);
    sleep_mode <= 1'b0;
    wr(`I2CM_OFF_STAT, 32'h8);
    frame_go <= 1'b1;
    repeat (8) @(posedge aclk);
    wr(`I2CM_OFF_CON2, 32'h1);
    rchk(`I2CM_OFF_CON2, 32'h1, 32'h0);
    wait_stat(3);
    frame_go <= 1'b0;
    rchk(`I2CM_OFF_STAT, 32'h4, 32'h4);
    wr(`I2CM_OFF_RATE, 32'h14);
    rchk(`I2CM_OFF_RATE, 32'hFF, 32'h14);
    wr(`I2CM_OFF_CON2, 32'h1);
    wr(`I2CM_OFF_CTRL, 32'h2);
    rchk(`I2CM_OFF_STAT, 32'h27, 32'h0);
    cmp({sda_oe_n, scl_oe_n}, 32'h3);
    rchk(`I2CM_OFF_CON2, 32'h1, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
